// [adcts_defs.svh]
// Constants of the converter trigger sequencer: register offsets,
// field positions, reset values and conversion timing.
// Assumes a 10 MHz system clock and byte addresses on a 32-bit bus.
`ifndef ADCTS_DEFS_SVH
`define ADCTS_DEFS_SVH

// Register byte offsets
`define ADCTS_OFS_CTRL0     8'h00
`define ADCTS_OFS_CTRL1     8'h04
`define ADCTS_OFS_CHSEL     8'h08
`define ADCTS_OFS_EVSEL     8'h0C
`define ADCTS_OFS_RES_BASE  8'h40
`define ADCTS_OFS_RES_LAST  8'h64

// Control register zero fields
`define ADCTS_C0_EN     7
`define ADCTS_C0_RUN    6
`define ADCTS_C0_TRG_HI 5
`define ADCTS_C0_TRG_LO 4
`define ADCTS_C0_SCAN   3
`define ADCTS_C0_BUF4   2

// Control register one: trigger pattern lies in bits 5:4, bit 3 zero
`define ADCTS_C1_TRG_HI 5
`define ADCTS_C1_TRG_LO 4

// Reset values
`define ADCTS_RST_CTRL1 8'h00
`define ADCTS_RST_CHSEL 4'h0
`define ADCTS_RST_EVSEL 3'h0

// Channels, slots and result width
`define ADCTS_NCH       10
`define ADCTS_LAST_CH   4'h9
`define ADCTS_RES_W     10

// Conversion timing
`define ADCTS_CLK_PERIOD_NS 100
`define ADCTS_CONV_TIME_NS  2000
`define ADCTS_CONV_CYCLES   ((`ADCTS_CONV_TIME_NS + `ADCTS_CLK_PERIOD_NS - 1) / `ADCTS_CLK_PERIOD_NS)
`define ADCTS_CNT_W         5

`endif

// [adcts_pkg.sv]
// Types of the converter trigger sequencer.
// Assumes adcts_defs.svh on the include path.
`include "adcts_defs.svh"

package adcts_pkg;

   typedef enum logic [1:0] {
      ADCTS_TRG_SW    = 2'b00,
      ADCTS_TRG_TIMER = 2'b01,
      ADCTS_TRG_EXT   = 2'b10,
      ADCTS_TRG_RSV   = 2'b11
   } adcts_trg_t;

   typedef struct packed {
      logic                       busy;
      logic [`ADCTS_CNT_W-1:0]    cnt;
      logic [3:0]                 chan;
      logic                       sample;
      logic                       done;
      logic [`ADCTS_RES_W-1:0]    data;
   } adcts_eng_st_t;

   typedef struct packed {
      logic [`ADCTS_NCH-1:0][`ADCTS_RES_W-1:0] slot;
   } adcts_bank_st_t;

   typedef struct packed {
      logic        en;
      adcts_trg_t  trg;
      logic        scan;
      logic        buf4;
      logic [7:0]  c1;
      logic [3:0]  chsel;
      logic [2:0]  evsel;
      logic        run;
      logic [3:0]  idx;
      logic        start;
      logic        abort;
      logic        irq;
      logic        ack;
      logic [31:0] dat;
   } adcts_top_st_t;

endpackage : adcts_pkg

// [adcts_conv_engine.sv]
// Conversion timing engine: drives the analog channel select, counts
// the conversion time and captures the comparator result.
// Assumes adc_data_i is valid at the end of the conversion time.
`timescale 1ns/1ns
`include "adcts_defs.svh"

module adcts_conv_engine
   import adcts_pkg::*;
(
   // Clock and reset
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   // Sequencer side
   input  wire logic                     start_i,
   input  wire logic                     abort_i,
   input  wire logic [3:0]               chan_i,
   output logic                          done_o,
   output logic [`ADCTS_RES_W-1:0]       data_o,
   // Analog side
   input  wire logic [`ADCTS_RES_W-1:0]  adc_data_i,
   output logic [3:0]                    analog_channel_o,
   output logic                          conv_sample_o
);

   localparam logic [`ADCTS_CNT_W-1:0] CONV_LAST = `ADCTS_CNT_W'(`ADCTS_CONV_CYCLES - 1);

   adcts_eng_st_t s_r;
   adcts_eng_st_t s_nxt;

   always_comb begin
      s_nxt        = s_r;
      s_nxt.sample = 1'b0;
      s_nxt.done   = 1'b0;
      if (start_i) begin
         // Restart drops whatever was in progress
         s_nxt.busy   = 1'b1;
         s_nxt.cnt    = CONV_LAST;
         s_nxt.chan   = chan_i;
         s_nxt.sample = 1'b1;
      end else if (abort_i) begin
         s_nxt.busy = 1'b0;
      end else if (s_r.busy) begin
         if (s_r.cnt == '0) begin
            s_nxt.busy = 1'b0;
            s_nxt.done = 1'b1;
            s_nxt.data = adc_data_i;
         end else begin
            s_nxt.cnt = s_r.cnt - 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign done_o           = s_r.done;
   assign data_o           = s_r.data;
   assign analog_channel_o = s_r.chan;
   assign conv_sample_o    = s_r.sample;

endmodule : adcts_conv_engine

// [adcts_result_bank.sv]
// Ten per-channel result slots with one write and one read port.
// Assumes writes come only from the sequencer at conversion end.
`timescale 1ns/1ns
`include "adcts_defs.svh"

module adcts_result_bank
   import adcts_pkg::*;
(
   // Clock and reset
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   // Write port
   input  wire logic                     we_i,
   input  wire logic [3:0]               wslot_i,
   input  wire logic [`ADCTS_RES_W-1:0]  wdata_i,
   // Read port
   input  wire logic [3:0]               rslot_i,
   output logic [`ADCTS_RES_W-1:0]       rdata_o
);

   adcts_bank_st_t s_r;
   adcts_bank_st_t s_nxt;

   always_comb begin
      s_nxt = s_r;
      if (we_i && (wslot_i <= `ADCTS_LAST_CH)) begin
         s_nxt.slot[wslot_i] = wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rdata_o = (rslot_i <= `ADCTS_LAST_CH) ? s_r.slot[rslot_i] : '0;

endmodule : adcts_result_bank

// [adcts_top.sv]
// Converter trigger sequencer: Wishbone register slave, trigger
// selection and conversion sequencing over ten analog channels.
// Assumes timer events are one-cycle pulses synchronous to clk_i.
//
// Notes on behaviour
// - Software-start mode converts as soon as the enable bit is set.
// - Single-buffer select: convert chosen channel, store, interrupt, repeat while enabled.
// - Four-buffer select: four conversions (two for 8, 9) into grouped slots.
// - Scan converts channels upward from zero into each channel's slot.
// - Scan last channel comes from the channel select field.
// - Software scan interrupts after last channel, then restarts while enabled.
// - Timer mode waits for event; running flag set while converting.
// - Timer event during conversion restarts the sequence from its start.
// - Writing a mode or channel register mid-conversion restarts sequence.
// - Timer single-buffer: one conversion, one store, one interrupt per event.
// - Timer single-buffer converts on every event while enabled.
// - Timer four-buffer: one event gives four conversions (two for 8, 9), then interrupt.
// - Next timer four-buffer run waits for another event.
// - Timer scan converts zero to last channel, then interrupts.
// - After timer scan, idle until next event, restart at zero.
// - Trigger mode is a two-bit field, mirrored in control register one.
// - Separate bits choose select or scan, and one or four buffers.
// - Event select register picks one of eight timer events.
// - Clearing enable stops conversion at once, storing nothing.
//
// Our own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ns
`include "adcts_defs.svh"

module adcts_top
   import adcts_pkg::*;
(
   // Clock and reset
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   // Wishbone slave
   input  wire logic                     wb_cyc_i,
   input  wire logic                     wb_stb_i,
   input  wire logic                     wb_we_i,
   input  wire logic [7:0]               wb_adr_i,
   input  wire logic [3:0]               wb_sel_i,
   input  wire logic [31:0]              wb_dat_i,
   output logic [31:0]                   wb_dat_o,
   output logic                          wb_ack_o,
   // Timer events: trig a/b of timers 0,1 then reversals
   input  wire logic [7:0]               timer_evt_i,
   // Analog multiplexer and comparator
   input  wire logic [`ADCTS_RES_W-1:0]  adc_data_i,
   output logic [3:0]                    analog_channel_o,
   output logic                          conv_sample_o,
   // Interrupt
   output logic                          conv_end_irq_o
);

   adcts_top_st_t s_r;
   adcts_top_st_t s_nxt;

   logic                     eng_done;
   logic [`ADCTS_RES_W-1:0]  eng_data;
   logic [`ADCTS_RES_W-1:0]  bank_rd;
   logic [3:0]               bank_rslot;
   logic                     store;
   logic                     bus_req;
   logic                     wr;
   logic                     cfg_wr;
   logic                     go;
   logic                     sw;
   logic                     tm;
   logic                     evt;
   logic                     last;
   logic [3:0]               sel_ch;
   logic [3:0]               scan_last;
   logic [3:0]               grp_base;
   logic [3:0]               cur_chan;
   logic [3:0]               cur_slot;
   logic                     res_hit;
   logic [31:0]              rd_word;

   // Channel and slot of the conversion in hand
   always_comb begin
      sel_ch    = (s_r.chsel > `ADCTS_LAST_CH) ? `ADCTS_LAST_CH : s_r.chsel;
      scan_last = sel_ch;
      if (sel_ch < 4'h4) begin
         grp_base = 4'h0;
      end else if (sel_ch < 4'h8) begin
         grp_base = 4'h4;
      end else begin
         grp_base = 4'h8;
      end
      if (s_r.scan) begin
         cur_chan = s_r.idx;
         cur_slot = s_r.idx;
         last     = (s_r.idx == scan_last);
      end else if (s_r.buf4) begin
         cur_chan = sel_ch;
         cur_slot = grp_base + s_r.idx;
         last     = (sel_ch >= 4'h8) ? (s_r.idx == 4'h1) : (s_r.idx == 4'h3);
      end else begin
         cur_chan = sel_ch;
         cur_slot = sel_ch;
         last     = 1'b1;
      end
   end

   // Bus read decode
   assign res_hit    = (wb_adr_i >= `ADCTS_OFS_RES_BASE) && (wb_adr_i <= `ADCTS_OFS_RES_LAST) &&
                       (wb_adr_i[1:0] == 2'b00);
   assign bank_rslot = 4'(wb_adr_i[5:2]);

   always_comb begin
      rd_word = 32'h0000_0000;
      if (res_hit) begin
         rd_word = {22'h00_0000, bank_rd};
      end else begin
         case (wb_adr_i)
            `ADCTS_OFS_CTRL0: begin
               rd_word = {24'h00_0000, s_r.en, s_r.run, s_r.trg, s_r.scan, s_r.buf4, 2'b00};
            end
            `ADCTS_OFS_CTRL1: begin
               rd_word = {24'h00_0000, s_r.c1[7:6], s_r.trg, 1'b0, s_r.c1[2:0]};
            end
            `ADCTS_OFS_CHSEL: begin
               rd_word = {28'h000_0000, s_r.chsel};
            end
            `ADCTS_OFS_EVSEL: begin
               rd_word = {29'h0000_0000, s_r.evsel};
            end
            default: begin
               rd_word = 32'h0000_0000;
            end
         endcase
      end
   end

   // Registers, bus handshake and sequencing
   always_comb begin
      s_nxt       = s_r;
      s_nxt.ack   = 1'b0;
      s_nxt.irq   = 1'b0;
      s_nxt.start = 1'b0;
      s_nxt.abort = 1'b0;
      store       = 1'b0;
      go          = 1'b0;
      cfg_wr      = 1'b0;
      bus_req     = wb_cyc_i & wb_stb_i;
      // Write takes effect on the edge that sees ack high
      wr          = s_r.ack & bus_req & wb_we_i & wb_sel_i[0];

      if (bus_req && !s_r.ack) begin
         s_nxt.ack = 1'b1;
         s_nxt.dat = rd_word;
      end

      if (wr) begin
         case (wb_adr_i)
            `ADCTS_OFS_CTRL0: begin
               s_nxt.en   = wb_dat_i[`ADCTS_C0_EN];
               s_nxt.trg  = adcts_trg_t'(wb_dat_i[`ADCTS_C0_TRG_HI:`ADCTS_C0_TRG_LO]);
               s_nxt.scan = wb_dat_i[`ADCTS_C0_SCAN];
               s_nxt.buf4 = wb_dat_i[`ADCTS_C0_BUF4];
               cfg_wr     = 1'b1;
            end
            `ADCTS_OFS_CTRL1: begin
               s_nxt.c1  = wb_dat_i[7:0];
               s_nxt.trg = adcts_trg_t'(wb_dat_i[`ADCTS_C1_TRG_HI:`ADCTS_C1_TRG_LO]);
               cfg_wr    = 1'b1;
            end
            `ADCTS_OFS_CHSEL: begin
               s_nxt.chsel = wb_dat_i[3:0];
               cfg_wr      = 1'b1;
            end
            `ADCTS_OFS_EVSEL: begin
               s_nxt.evsel = wb_dat_i[2:0];
            end
            default: begin
               cfg_wr = 1'b0;
            end
         endcase
      end

      sw  = (s_nxt.trg == ADCTS_TRG_SW);
      tm  = (s_nxt.trg == ADCTS_TRG_TIMER);
      evt = timer_evt_i[s_r.evsel];

      if (!s_nxt.en) begin
         // Partial result is dropped, no slot written
         s_nxt.abort = s_r.run;
         s_nxt.run   = 1'b0;
      end else if (!s_r.en || cfg_wr) begin
         if (sw) begin
            go = 1'b1;
         end else if (tm && s_r.run) begin
            go = 1'b1;
         end else begin
            s_nxt.abort = s_r.run;
            s_nxt.run   = 1'b0;
         end
      end else if (tm && evt) begin
         // Event beats a same-cycle conversion end: restart, nothing stored
         go = 1'b1;
      end else if (eng_done && s_r.run && !s_r.start) begin
         // A done from a conversion being replaced never reaches a slot
         store = 1'b1;
         if (last) begin
            s_nxt.irq = 1'b1;
            if (sw) begin
               go = 1'b1;
            end else begin
               s_nxt.run = 1'b0;
            end
         end else begin
            s_nxt.idx   = s_r.idx + 4'h1;
            s_nxt.start = 1'b1;
         end
      end

      if (go) begin
         s_nxt.run   = 1'b1;
         s_nxt.idx   = 4'h0;
         s_nxt.start = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r       <= '0;
         s_r.trg   <= ADCTS_TRG_SW;
         s_r.c1    <= `ADCTS_RST_CTRL1;
         s_r.chsel <= `ADCTS_RST_CHSEL;
         s_r.evsel <= `ADCTS_RST_EVSEL;
      end else begin
         s_r <= s_nxt;
      end
   end

   adcts_conv_engine u_engine (
      .clk_i            (clk_i),
      .rst_i            (rst_i),
      .start_i          (s_r.start),
      .abort_i          (s_r.abort),
      .chan_i           (cur_chan),
      .done_o           (eng_done),
      .data_o           (eng_data),
      .adc_data_i       (adc_data_i),
      .analog_channel_o (analog_channel_o),
      .conv_sample_o    (conv_sample_o)
   );

   adcts_result_bank u_bank (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .we_i    (store),
      .wslot_i (cur_slot),
      .wdata_i (eng_data),
      .rslot_i (bank_rslot),
      .rdata_o (bank_rd)
   );

   assign wb_ack_o       = s_r.ack;
   assign wb_dat_o       = s_r.dat;
   assign conv_end_irq_o = s_r.irq;

endmodule : adcts_top

// [adcts_monitor.sv]
// Port checker for the converter trigger sequencer.
// Assumes it is bound to adcts_top and sees only its ports.
`timescale 1ns/1ns

module adcts_monitor (
   // Clock and reset
   input wire logic       clk_i,
   input wire logic       rst_i,
   // Register bus
   input wire logic       wb_cyc_i,
   input wire logic       wb_stb_i,
   input wire logic       wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic       wb_ack_o,
   // Converter side
   input wire logic [3:0] analog_channel_o,
   input wire logic       conv_sample_o,
   input wire logic       conv_end_irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered next cycle");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_irq_single: assert property (conv_end_irq_o |=> !conv_end_irq_o)
      else $error("end interrupt longer than one cycle");
   a_irq_after_conv: assert property (conv_end_irq_o |-> $past(conv_sample_o, 21))
      else $error("end interrupt without full conversion");
   a_sample_single: assert property (conv_sample_o |=> !conv_sample_o)
      else $error("sample pulse longer than one cycle");
   a_chan_range: assert property (conv_sample_o |-> analog_channel_o <= 4'h9)
      else $error("channel beyond last input");
   a_ctrl1_bit3: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h04 |-> !wb_dat_o[3])
      else $error("control one bit 3 not zero");
   a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h10 |-> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
endmodule : adcts_monitor

bind adcts_top adcts_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .analog_channel_o(analog_channel_o), .conv_sample_o(conv_sample_o),
   .conv_end_irq_o(conv_end_irq_o));

// [adcts_analog_model.sv]
// Model of the analog multiplexer and the timer event sources.
// Assumes fire requests come from the bench one cycle long.
`timescale 1ns/1ns

module adcts_analog_model (
   // Clock
   input wire logic       clk_i,
   // Bench control
   input wire logic       fire_i,
   input wire logic [2:0] fire_sel_i,
   input wire logic [5:0] level_i,
   // Device side
   input wire logic [3:0] analog_channel_i,
   output logic [9:0]     adc_data_o,
   output logic [7:0]     timer_evt_o
);
   // Each channel reads its own number under a common level
   assign adc_data_o = {level_i, analog_channel_i};

   // One event line pulses for one cycle
   always @(posedge clk_i) begin
      timer_evt_o <= fire_i ? (8'h01 << fire_sel_i) : 8'h00;
   end
endmodule : adcts_analog_model

// [test_adc_trigger_sequencer.sv]
// Self-checking bench of the converter trigger sequencer.
// Assumes adcts_top, adcts_analog_model and the bound checker.
`timescale 1ns/1ns

module test_adc_trigger_sequencer;
   import adcts_pkg::*;
   typedef struct packed {
      logic [3:0] trg, scan, buf4, ch, ev;
      logic [7:0] offs;
      logic [3:0] fs, ns;
   } adcts_row_t;
   logic        clk_i = 0, rst_i = 1, fire = 0;
   logic        wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, smp, irq;
   logic [7:0]  wb_adr_i = 8'h00, tevt;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic [3:0]  chan;
   logic [9:0]  adc;
   logic [2:0]  fsel = 3'h0;
   logic [5:0]  lvl = 6'h00;
   int err_total = 0, total_checks = 0, irq_cnt = 0, smp_cnt = 0, cyc_cnt = 0, n0, s0;
   adcts_row_t r;
   adcts_row_t rows[11] = '{36'h0_0_0_2_0_05_2_1, 36'h0_0_1_3_0_09_0_4, 36'h0_1_0_5_0_0C_0_6,
      36'h1_0_0_9_7_11_9_1, 36'h1_0_1_8_4_16_8_2, 36'h1_0_1_6_2_1A_4_4, 36'h1_1_0_4_0_1F_0_5,
      36'h1_0_0_0_1_21_0_1, 36'h1_0_0_7_3_25_7_1, 36'h1_1_0_1_6_29_0_2, 36'h1_1_0_9_5_23_0_A};
   logic [7:0]  ra[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h40};

   adcts_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timer_evt_i(tevt), .adc_data_i(adc),
      .analog_channel_o(chan), .conv_sample_o(smp), .conv_end_irq_o(irq));
   adcts_analog_model u_far (.clk_i(clk_i), .fire_i(fire), .fire_sel_i(fsel), .level_i(lvl),
      .analog_channel_i(chan), .adc_data_o(adc), .timer_evt_o(tevt));

   initial begin
      forever #50 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      irq_cnt <= irq_cnt + (irq === 1'b1);
      smp_cnt <= smp_cnt + (smp === 1'b1);
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 30000) begin
         err_total++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wb_cyc_i <= 1;
      wb_stb_i <= 1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 0;
      wb_stb_i <= 0;
   endtask : wb

   task automatic fire_evt(input logic [2:0] e);
      @(posedge clk_i);
      fire <= 1;
      fsel <= e;
      @(posedge clk_i);
      fire <= 0;
   endtask : fire_evt

   task automatic wait_irq(input int n);
      for (int k = 0; k < 3000 && irq_cnt == n; k++) @(posedge clk_i);
   endtask : wait_irq

   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 0;
      wb(1, 8'h10, 32'hFF);
      foreach (ra[j]) begin
         wb(0, ra[j], 32'h0);
         chk(rd, 32'h0);
      end
      foreach (rows[i]) begin
         r = rows[i];
         lvl <= r.offs[5:0];
         wb(1, 8'h0C, {29'h0, r.ev[2:0]});
         wb(1, 8'h08, {28'h0, r.ch});
         n0 = irq_cnt;
         wb(1, 8'h00, {24'h0, 2'b10, r.trg[1:0], r.scan[0], r.buf4[0], 2'b00});
         if (r.trg[0]) begin
            fire_evt(r.ev[2:0]);
            wb(0, 8'h00, 32'h0);
            chk({31'h0, rd[6]}, 32'h1);
         end
         wait_irq(n0);
         wb(0, 8'h00, 32'h0);
         chk({31'h0, rd[6]}, {31'h0, ~r.trg[0]});
         if (r.trg[0]) begin
            repeat (60) @(posedge clk_i);
            chk(irq_cnt, n0 + 1);
         end
         wb(1, 8'h00, 32'h0);
         for (int k = 0; k < r.ns; k++) begin
            wb(0, 8'h40 + 8'(4 * (r.fs + k)), 32'h0);
            chk(rd, {22'h0, r.offs[5:0], r.scan[0] ? 4'(r.fs + k) : r.ch});
         end
      end
      // Clearing enable mid-conversion keeps the old slot
      lvl <= 6'h3C;
      wb(1, 8'h08, 32'h1);
      n0 = irq_cnt;
      wb(1, 8'h00, 32'h80);
      repeat (10) @(posedge clk_i);
      wb(1, 8'h00, 32'h0);
      repeat (40) @(posedge clk_i);
      chk(irq_cnt, n0);
      wb(0, 8'h44, 32'h0);
      chk(rd, 32'h231);
      // External and reserved modes never start, even on the selected event
      wb(1, 8'h0C, 32'h0);
      s0 = smp_cnt;
      wb(1, 8'h00, 32'hA0);
      fire_evt(3'h0);
      repeat (40) @(posedge clk_i);
      chk(smp_cnt, s0);
      wb(1, 8'h00, 32'hB0);
      fire_evt(3'h0);
      repeat (40) @(posedge clk_i);
      chk(smp_cnt, s0);
      wb(1, 8'h00, 32'h0);
      wb(1, 8'h04, 32'hDF);
      wb(0, 8'h04, 32'h0);
      chk(rd, 32'hD7);
      wb(0, 8'h00, 32'h0);
      chk(rd, 32'h10);
      // Second event and channel write both restart the run
      lvl <= 6'h2A;
      wb(1, 8'h08, 32'h6);
      wb(1, 8'h00, 32'h90);
      n0 = irq_cnt;
      s0 = smp_cnt;
      fire_evt(3'h0);
      repeat (10) @(posedge clk_i);
      fire_evt(3'h0);
      wait_irq(n0);
      repeat (30) @(posedge clk_i);
      chk(irq_cnt, n0 + 1);
      chk(smp_cnt, s0 + 2);
      lvl <= 6'h2B;
      fire_evt(3'h0);
      repeat (8) @(posedge clk_i);
      wb(1, 8'h08, 32'h7);
      wait_irq(n0 + 1);
      wb(0, 8'h58, 32'h0);
      chk(rd, 32'h2A6);
      wb(0, 8'h5C, 32'h0);
      chk(rd, 32'h2B7);
      // Reset in mid-run drops the sequence and clears registers and slots
      n0 = irq_cnt;
      fire_evt(3'h0);
      repeat (5) @(posedge clk_i);
      rst_i <= 1;
      repeat (2) @(posedge clk_i);
      rst_i <= 0;
      repeat (40) @(posedge clk_i);
      chk(irq_cnt, n0);
      wb(0, 8'h00, 32'h0);
      chk(rd, 32'h0);
      wb(0, 8'h5C, 32'h0);
      chk(rd, 32'h0);
      end_of_test();
   end
endmodule : test_adc_trigger_sequencer
